// ---- rtl/io_rack_bus_adapter.sv ----
`timescale 1ns/10ps
`include "io_rack_defs.svh"
// Notes on behaviour
// R1 - Sixteen byte locations, seven implemented, byte access
// R2 - Host touches only the seven implemented locations
// R3 - Offset zero bit 0 sets rack reset level
// R4 - Reset control write restarts 150 ms hold flag
// R5 - Offset zero reads level bit0, hold flag bit7
// R6 - Offset one holds six-bit bank address
// R7 - Host keeps bank address steady while busy
// R8 - Host loads data register before write cycle
// R9 - Read cycle result held in data register
// R10 - Host avoids data and trigger while busy
// R11 - Reading offset three starts read, returns 0xab
// R12 - Host sets bank address before read trigger
// R13 - Writing offset three starts write cycle
// R14 - Status bit 0 shows cycle in progress
// R15 - Status bits 2:1 hold last responder id
// R16 - Status bit5 write, bit6 read, bits4:3 zero
// R17 - Offset five returns six switches, upper zero
// R18 - Offset six returns engine version number
// R19 - Reset: level high, busy and status clear
// R20 - Switch bit 4 picks 2700 or 3300 ns strobe
// R21 - High latency adds 3600 ns gap between cycles
// R22 - Reset line independent of running cycle
// R23 - Drive address, pulse strobe, capture, clear busy
module io_rack_bus_adapter #(
  parameter int unsigned RESET_HOLD_CYCLES = `RESET_HOLD_CYC,
  parameter logic [7:0]  ENGINE_VERSION    = `ENGINE_VERSION_INIT
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire io_rack_pkg::host_req_type host_req,
  output io_rack_pkg::host_rsp_type   host_rsp,
  input  wire io_rack_pkg::rack_in_type  rack_in,
  output io_rack_pkg::rack_out_type   rack_out
);
  import io_rack_pkg::*;

  localparam logic [`CYC_CNT_W-1:0] STROBE_SHORT =
    `CYC_CNT_W'(`STROBE_SHORT_CYC);
  localparam logic [`CYC_CNT_W-1:0] STROBE_LONG =
    `CYC_CNT_W'(`STROBE_LONG_CYC);
  localparam logic [`CYC_CNT_W-1:0] GAP_LEN =
    `CYC_CNT_W'(`IDLE_GAP_CYC);
  localparam logic [`CYC_CNT_W-1:0] SETUP_LEN =
    `CYC_CNT_W'(`SETUP_CYC);
  localparam logic [`CYC_CNT_W-1:0] HOLD_LEN =
    `CYC_CNT_W'(`HOLD_CYC);
  localparam logic [`RESET_TIMER_W-1:0] HOLD_LOAD =
    `RESET_TIMER_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [`CYC_CNT_W-1:0] CNT_ONE = `CYC_CNT_W'(1);

  // Synchronised pin inputs
  logic [7:0]           data_in_s;
  logic [1:0]           id_in_s;
  logic [`SWITCH_W-1:0] switch_s;

  // Host-visible registers
  logic                     reset_ctrl_r;
  logic                     reset_busy_r;
  logic [`RESET_TIMER_W-1:0] reset_timer_r;
  logic [`BANK_W-1:0]       bank_r;
  logic [7:0]               data_r;
  logic [1:0]               resp_id_r;
  logic                     write_status_r;
  logic                     read_status_r;

  // Cycle engine
  engine_state_type         state_r;
  logic [`CYC_CNT_W-1:0]    cnt_r;
  logic [`CYC_CNT_W-1:0]    strobe_len_r;
  logic                     high_latency_r;
  logic                     busy_r;
  logic                     cyc_write_r;
  logic                     cnt_done;
  logic                     start_rd;
  logic                     start_wr;
  logic                     capture;

  // Pin output registers
  logic [`BANK_W-1:0]       bank_out_r;
  logic [7:0]               data_out_r;
  logic                     data_oe_n_r;
  logic                     rd_strobe_n_r;
  logic                     wr_strobe_n_r;

  // Host answer
  logic [7:0]               rdata_r;
  logic [7:0]               rdata_nxt;
  logic                     rvalid_r;
  logic                     wr_reset;
  logic                     wr_bank;
  logic                     wr_data;

  pin_sync #(.W(8)) u_data_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (rack_in.data_in),
    .level (data_in_s)
  );

  pin_sync #(.W(2)) u_id_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (rack_in.responder_id),
    .level (id_in_s)
  );

  pin_sync #(.W(`SWITCH_W)) u_switch_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (rack_in.switches),
    .level (switch_s)
  );

  // Address decode; only byte locations 0 to 6 respond
  assign wr_reset = host_req.wr && (host_req.addr == `OFS_RESET);   // [R1]
  assign wr_bank  = host_req.wr && (host_req.addr == `OFS_BANK);    // [R1]
  assign wr_data  = host_req.wr && (host_req.addr == `OFS_DATA);    // [R1]

  // Triggers while busy are dropped; the host must not issue them
  assign start_rd = host_req.rd && (host_req.addr == `OFS_TRIGGER)
                    && (state_r == ENG_IDLE);                       // [R11] [R10]
  assign start_wr = host_req.wr && (host_req.addr == `OFS_TRIGGER)
                    && (state_r == ENG_IDLE);                       // [R13] [R10]
  assign cnt_done = (cnt_r == '0);
  assign capture  = (state_r == ENG_STROBE) && cnt_done;

  // Rack reset level, unrelated to the cycle engine
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_ctrl_r <= `RESET_CTRL_INIT;                             // [R19]
    end else if (wr_reset) begin
      reset_ctrl_r <= host_req.wdata[`RST_LEVEL_BIT];               // [R3] [R22]
    end
  end

  // Minimum reset hold timer, restarted on every control write
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_busy_r  <= 1'b0;
      reset_timer_r <= '0;
    end else if (wr_reset) begin
      reset_busy_r  <= 1'b1;                                        // [R4]
      reset_timer_r <= HOLD_LOAD;                                   // [R4]
    end else if (reset_busy_r) begin
      if (reset_timer_r == '0) begin
        reset_busy_r <= 1'b0;                                       // [R4]
      end else begin
        reset_timer_r <= reset_timer_r - `RESET_TIMER_W'(1);
      end
    end
  end

  // Bank address; the engine latches it at cycle start
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_r <= '0;
    end else if (wr_bank) begin
      bank_r <= host_req.wdata[`BANK_W-1:0];                        // [R6] [R7]
    end
  end

  // Data register; a read capture wins over a host write
  always_ff @(posedge clk) begin
    if (rst) begin
      data_r <= '0;
    end else if (capture && !cyc_write_r) begin
      data_r <= data_in_s;                                          // [R9]
    end else if (wr_data) begin
      data_r <= host_req.wdata;                                     // [R8]
    end
  end

  // Cycle sequencer: setup, strobe, hold, optional idle gap
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r        <= ENG_IDLE;
      cnt_r          <= '0;
      strobe_len_r   <= STROBE_SHORT;
      high_latency_r <= 1'b1;
      busy_r         <= 1'b0;                                       // [R19]
      cyc_write_r    <= 1'b0;
    end else begin
      case (state_r)
        ENG_IDLE: begin
          if (start_rd || start_wr) begin
            state_r     <= ENG_SETUP;
            cnt_r       <= SETUP_LEN - CNT_ONE;
            busy_r      <= 1'b1;                                    // [R14]
            cyc_write_r <= start_wr;
            strobe_len_r <= switch_s[`SW_STROBE_BIT] ?
                            STROBE_LONG : STROBE_SHORT;             // [R20]
            high_latency_r <= !switch_s[`SW_LATENCY_BIT];           // [R21]
          end
        end
        ENG_SETUP: begin
          if (cnt_done) begin
            state_r <= ENG_STROBE;
            cnt_r   <= strobe_len_r - CNT_ONE;                      // [R20] [R23]
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ENG_STROBE: begin
          if (cnt_done) begin
            state_r <= ENG_HOLD;
            cnt_r   <= HOLD_LEN - CNT_ONE;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ENG_HOLD: begin
          if (cnt_done && high_latency_r) begin
            state_r <= ENG_GAP;
            cnt_r   <= GAP_LEN - CNT_ONE;                           // [R21]
          end else if (cnt_done) begin
            state_r <= ENG_IDLE;
            busy_r  <= 1'b0;                                        // [R23] [R14]
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ENG_GAP: begin
          if (cnt_done) begin
            state_r <= ENG_IDLE;
            busy_r  <= 1'b0;                                        // [R21] [R14]
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          state_r <= ENG_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // Cycle kind and responder id, kept until the next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      write_status_r <= 1'b0;                                       // [R19]
      read_status_r  <= 1'b0;                                       // [R19]
      resp_id_r      <= '0;
    end else begin
      if (start_rd || start_wr) begin
        write_status_r <= start_wr;                                 // [R16]
        read_status_r  <= start_rd;                                 // [R16]
      end
      if (capture) begin
        resp_id_r <= id_in_s;                                       // [R15]
      end
    end
  end

  // Rack bus pins; address and write data frozen for the whole cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_out_r    <= '0;
      data_out_r    <= '0;
      data_oe_n_r   <= 1'b1;
      rd_strobe_n_r <= 1'b1;
      wr_strobe_n_r <= 1'b1;
    end else begin
      if (start_rd || start_wr) begin
        bank_out_r <= bank_r;                                       // [R23] [R12]
        data_out_r <= data_r;                                       // [R23]
      end
      if (start_wr) begin
        data_oe_n_r <= 1'b0;                                        // [R13]
      end else if ((state_r == ENG_HOLD) && cnt_done) begin
        data_oe_n_r <= 1'b1;
      end
      if ((state_r == ENG_SETUP) && cnt_done) begin
        rd_strobe_n_r <= cyc_write_r;                               // [R23]
        wr_strobe_n_r <= !cyc_write_r;                              // [R23]
      end else if (capture) begin
        rd_strobe_n_r <= 1'b1;
        wr_strobe_n_r <= 1'b1;
      end
    end
  end

  // Read multiplexer; unmapped locations answer zero
  always_comb begin
    rdata_nxt = `UNMAPPED_READ_VALUE;                               // [R1] [R2]
    case (host_req.addr)
      `OFS_RESET: begin
        rdata_nxt[`RST_LEVEL_BIT] = reset_ctrl_r;                   // [R5]
        rdata_nxt[`RST_BUSY_BIT]  = reset_busy_r;                   // [R5]
      end
      `OFS_BANK: begin
        rdata_nxt[`BANK_W-1:0] = bank_r;                            // [R6]
      end
      `OFS_DATA: begin
        rdata_nxt = data_r;                                         // [R9]
      end
      `OFS_TRIGGER: begin
        rdata_nxt = `TRIGGER_READ_VALUE;                            // [R11]
      end
      `OFS_STATUS: begin
        rdata_nxt[`ST_BUSY_BIT]  = busy_r;                          // [R14]
        rdata_nxt[`ST_ID_LO_BIT] = resp_id_r[0];                    // [R15]
        rdata_nxt[`ST_ID_HI_BIT] = resp_id_r[1];                    // [R15]
        rdata_nxt[`ST_WRITE_BIT] = write_status_r;                  // [R16]
        rdata_nxt[`ST_READ_BIT]  = read_status_r;                   // [R16]
      end
      `OFS_SWITCH: begin
        rdata_nxt[`SWITCH_W-1:0] = switch_s;                        // [R17]
      end
      `OFS_VERSION: begin
        rdata_nxt = ENGINE_VERSION;                                 // [R18]
      end
      default: begin
        rdata_nxt = `UNMAPPED_READ_VALUE;
      end
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_req.rd;
      if (host_req.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign host_rsp.rdata  = rdata_r;
  assign host_rsp.rvalid = rvalid_r;

  // Line is high while the control bit is zero
  assign rack_out.reset_level = !reset_ctrl_r;                      // [R3] [R19]
  assign rack_out.bank_addr   = bank_out_r;
  assign rack_out.data_out    = data_out_r;
  assign rack_out.data_oe_n   = data_oe_n_r;
  assign rack_out.rd_strobe_n = rd_strobe_n_r;
  assign rack_out.wr_strobe_n = wr_strobe_n_r;
endmodule

// ---- common/io_rack_defs.svh ----
`ifndef IO_RACK_DEFS_SVH
`define IO_RACK_DEFS_SVH

// Register window
`define WINDOW_LOCATIONS     16
`define IMPLEMENTED_LOCS     7
`define OFS_RESET            4'h0
`define OFS_BANK             4'h1
`define OFS_DATA             4'h2
`define OFS_TRIGGER          4'h3
`define OFS_STATUS           4'h4
`define OFS_SWITCH           4'h5
`define OFS_VERSION          4'h6

// Field positions
`define RST_LEVEL_BIT        0
`define RST_BUSY_BIT         7
`define ST_BUSY_BIT          0
`define ST_ID_LO_BIT         1
`define ST_ID_HI_BIT         2
`define ST_WRITE_BIT         5
`define ST_READ_BIT          6
`define SW_STROBE_BIT        4
`define SW_LATENCY_BIT       5
`define BANK_W               6
`define SWITCH_W             6

// Values
`define TRIGGER_READ_VALUE   8'hab
`define RESET_CTRL_INIT      1'b0
`define ENGINE_VERSION_INIT  8'h01
`define UNMAPPED_READ_VALUE  8'h00

// Times in their own units
`define CLK_PERIOD_NS        50
`define STROBE_SHORT_NS      2700
`define STROBE_LONG_NS       3300
`define IDLE_GAP_NS          3600
`define SETUP_NS             100
`define HOLD_NS              100
`define RESET_HOLD_MS        150

// Derived cycle counts, least times rounded up
`define NS_TO_CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_SHORT_CYC     `NS_TO_CYC_UP(`STROBE_SHORT_NS)
`define STROBE_LONG_CYC      `NS_TO_CYC_UP(`STROBE_LONG_NS)
`define IDLE_GAP_CYC         `NS_TO_CYC_UP(`IDLE_GAP_NS)
`define SETUP_CYC            `NS_TO_CYC_UP(`SETUP_NS)
`define HOLD_CYC             `NS_TO_CYC_UP(`HOLD_NS)
`define RESET_HOLD_CYC       `NS_TO_CYC_UP(`RESET_HOLD_MS * 1000000)
`define CYC_CNT_W            7
`define RESET_TIMER_W        22

`endif

// ---- common/io_rack_pkg.sv ----
package io_rack_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } host_rsp_type;

  typedef struct packed {
    logic [5:0] bank_addr;
    logic [7:0] data_out;
    logic       data_oe_n;
    logic       rd_strobe_n;
    logic       wr_strobe_n;
    logic       reset_level;
  } rack_out_type;

  typedef struct packed {
    logic [7:0] data_in;
    logic [1:0] responder_id;
    logic [5:0] switches;
  } rack_in_type;

  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_SETUP,
    ENG_STROBE,
    ENG_HOLD,
    ENG_GAP
  } engine_state_type;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/10ps
// Three-stage pin synchroniser; output follows once stages two and three agree
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] meta_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
    end else begin
      meta_r <= pin;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ---- dv/io_rack_chk.sv ----
`timescale 1ns/10ps
`include "io_rack_defs.svh"
module io_rack_chk (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire io_rack_pkg::host_req_type host_req,
  input wire io_rack_pkg::host_rsp_type host_rsp,
  input wire io_rack_pkg::rack_out_type rack_out
);
  import io_rack_pkg::*;
  logic [7:0] low_cnt_r;
  wire        strobe_idle = rack_out.rd_strobe_n & rack_out.wr_strobe_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the current strobe
  always_ff @(posedge clk) begin
    if (rst || strobe_idle) begin
      low_cnt_r <= 8'h00;
    end else begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end
  property p_rvalid; host_req.rd |=> host_rsp.rvalid; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered");
  property p_rvalid_only; host_rsp.rvalid |-> $past(host_req.rd); endproperty
  a_rvalid_only: assert property (p_rvalid_only)
    else $error("answer without read");
  property p_trig_read;
    host_req.rd && host_req.addr == 4'h3 |=> host_rsp.rdata == 8'hab;
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("trigger read value wrong");
  property p_rst_level;
    host_req.wr && host_req.addr == 4'h0
      |=> rack_out.reset_level == !$past(host_req.wdata[0]);
  endproperty
  a_rst_level: assert property (p_rst_level)
    else $error("reset level not following write");
  property p_level_hold;
    !(host_req.wr && host_req.addr == 4'h0) |=> $stable(rack_out.reset_level);
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("reset level moved without write");
  property p_excl; rack_out.rd_strobe_n || rack_out.wr_strobe_n; endproperty
  a_excl: assert property (p_excl)
    else $error("both strobes low");
  property p_strobe_len;
    $rose(strobe_idle) |-> low_cnt_r == `STROBE_SHORT_CYC
                        || low_cnt_r == `STROBE_LONG_CYC;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe length wrong");
  property p_oe; !rack_out.wr_strobe_n |-> !rack_out.data_oe_n; endproperty
  a_oe: assert property (p_oe)
    else $error("write strobe without driven data");
  property p_bank; !strobe_idle |-> $stable(rack_out.bank_addr); endproperty
  a_bank: assert property (p_bank)
    else $error("bank moved during strobe");
endmodule
bind io_rack_bus_adapter io_rack_chk u_chk (.clk(clk), .rst(rst),
  .host_req(host_req), .host_rsp(host_rsp), .rack_out(rack_out));

// ---- dv/rack_model.sv ----
`timescale 1ns/10ps
module rack_model (
  input wire logic                      clk,
  input wire io_rack_pkg::rack_out_type bus,
  output logic [7:0]                    data_in,
  output logic [1:0]                    responder_id
);
  import io_rack_pkg::*;
  logic [7:0] mem [64];
  initial begin
    data_in = 8'h00;
    responder_id = 2'b00;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'hff - 8'(i);
    end
  end
  // Released bus toggles every cycle
  always @(posedge clk) begin
    if (!bus.rd_strobe_n || !bus.wr_strobe_n) begin
      responder_id <= bus.bank_addr[1:0];
    end else begin
      responder_id <= ~responder_id;
    end
    if (!bus.rd_strobe_n) begin
      data_in <= mem[bus.bank_addr];
    end else begin
      data_in <= ~data_in;
    end
    if (!bus.wr_strobe_n && !bus.data_oe_n) begin
      mem[bus.bank_addr] <= bus.data_out;
    end
  end
endmodule

// ---- dv/io_rack_bus_adapter_test.sv ----
`timescale 1ns/10ps
module io_rack_bus_adapter_test;
  import io_rack_pkg::*;
  localparam int         HOLD = 20;
  localparam logic [7:0] VER  = 8'h5c; // Arbitrary value
  logic         clk;
  logic         rst;
  host_req_type req;
  host_rsp_type rsp;
  rack_in_type  rin;
  rack_out_type rout;
  logic [5:0]   sw;
  logic [7:0]   rdat;
  logic [1:0]   rid;
  int           n_mismatch = 0;
  int           comparisons = 0;
  int           cyc = 0;
  assign rin = '{data_in: rdat, responder_id: rid, switches: sw};
  io_rack_bus_adapter #(.RESET_HOLD_CYCLES(HOLD), .ENGINE_VERSION(VER)) DUT (
    .clk(clk), .rst(rst), .host_req(req), .host_rsp(rsp),
    .rack_in(rin), .rack_out(rout));
  rack_model u_rack (.clk(clk), .bus(rout), .data_in(rdat),
    .responder_id(rid));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, exp, input string w);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, e,
                       input string w);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rsp.rdata & m, e, w);
    check({7'h00, rsp.rvalid}, 8'h01, "answer valid");
  endtask
  task automatic level_is(input logic v);
    @(posedge clk);
    #1;
    check({7'h00, rout.reset_level}, {7'h00, v}, "reset line");
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      rdchk(4'h4, 8'h18, 8'h00, "poll");
      if (rsp.rdata[0] === 1'b0) break;
    end
    rdchk(4'h4, 8'h01, 8'h00, "busy clear");
  endtask
  task automatic set_sw(input logic [5:0] v);
    @(posedge clk);
    sw <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_powerup;
    rdchk(4'h0, 8'h81, 8'h00, "reset state");
    rdchk(4'h4, 8'h79, 8'h00, "status at start");
    level_is(1'b1);
    $display("test powerup done");
  endtask
  task automatic t_regs;
    wr(4'h1, 8'hff);
    rdchk(4'h1, 8'hff, 8'h3f, "bank");
    wr(4'h2, 8'h96);
    rdchk(4'h2, 8'hff, 8'h96, "data");
    set_sw(6'h2a);
    rdchk(4'h5, 8'hff, 8'h2a, "switches");
    rdchk(4'h6, 8'hff, VER, "version");
    rdchk(4'h4, 8'h98, 8'h00, "status reserved");
    $display("test registers done");
  endtask
  task automatic t_reset_timer;
    wr(4'h0, 8'h01);
    level_is(1'b0);
    rdchk(4'h0, 8'h81, 8'h81, "hold set");
    repeat (8) @(posedge clk);
    wr(4'h0, 8'h01);
    repeat (14) @(posedge clk);
    rdchk(4'h0, 8'h81, 8'h81, "hold restarted");
    repeat (10) @(posedge clk);
    rdchk(4'h0, 8'h81, 8'h01, "hold expired");
    wr(4'h0, 8'h00);
    level_is(1'b1);
    $display("test reset timer done");
  endtask
  task automatic t_write_cyc;
    set_sw(6'h20);
    wr(4'h1, 8'h05);
    wr(4'h2, 8'hc3);
    wr(4'h3, 8'h00);
    rdchk(4'h4, 8'hf9, 8'h21, "write busy");
    wait_idle;
    rdchk(4'h4, 8'hff, 8'h22, "write done");
    check(u_rack.mem[5], 8'hc3, "rack got byte");
    $display("test write cycle done");
  endtask
  task automatic t_read_cyc;
    set_sw(6'h10);
    wr(4'h1, 8'h06);
    rdchk(4'h3, 8'hff, 8'hab, "read trigger");
    rdchk(4'h4, 8'hf9, 8'h41, "read busy");
    wr(4'h0, 8'h01);
    level_is(1'b0);
    wr(4'h0, 8'h00);
    repeat (110) @(posedge clk);
    rdchk(4'h4, 8'h01, 8'h01, "gap busy");
    wait_idle;
    rdchk(4'h2, 8'hff, 8'hf9, "read data");
    rdchk(4'h4, 8'hff, 8'h44, "read done");
    $display("test read cycle done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      $display("BAD at %0t: run too long", $time);
      wrap_up;
    end
  end
  initial begin
    req = '0;
    sw = 6'h00;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_powerup;
    t_regs;
    t_reset_timer;
    t_write_cyc;
    t_read_cyc;
    wrap_up;
  end
endmodule
